// >>> hw/option_latch_pkg.sv
package option_latch_pkg;
    // Register map, byte addresses on the word-wide bus
    localparam logic [7:0] OPTION_ADDR = 8'h1F;
    localparam logic [7:0] OPTION_BYTE_ADDR = 8'h7C;
    // Field positions inside the option byte
    localparam int SLOW_CRYSTAL_BIT = 7;
    localparam int UNDERVOLT_STOP_BIT = 6;
    localparam int UNDERVOLT_RESET_BIT = 5;
    localparam int UNDERVOLT_POWER_BIT = 4;
    localparam int WATCHDOG_RATE_BIT = 3;
    localparam int SHORT_RECOVERY_BIT = 2;
    localparam int STOP_ENABLE_BIT = 1;
    localparam int WATCHDOG_DISABLE_BIT = 0;
    // Defaults loaded by every reset
    localparam logic [7:0] OPTION_RESET = 8'h30;
    // Status word: bit 0 reads back whether the one write has been used
    localparam logic [7:0] STATUS_BYTE_ADDR = 8'h80;
    localparam int WRITTEN_BIT = 0;
    // Timing counts in system clock cycles
    localparam logic [17:0] WATCHDOG_FAST_CYCLES = 18'h01FF0;
    localparam logic [17:0] WATCHDOG_SLOW_CYCLES = 18'h3FFF0;
    localparam logic [12:0] RECOVERY_SHORT_CYCLES = 13'h0020;
    localparam logic [12:0] RECOVERY_LONG_CYCLES = 13'h1000;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// >>> hw/write_once_option_register.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module write_once_option_register (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic slow_crystal_select_out,
    output logic undervolt_power_enable_out,
    output logic undervolt_stop_active_out,
    output logic undervolt_reset_request_in_gated_out,
    input wire logic undervolt_reset_request_in,
    output logic [17:0] watchdog_timeout_cycles_out,
    output logic watchdog_disable_out,
    input wire logic stop_opcode_in,
    output logic stop_illegal_out,
    output logic stop_execute_out,
    input wire logic stop_exit_by_reset_pin_in,
    output logic [12:0] stop_recovery_cycles_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers

    logic rst_meta;
    logic rst_sync_n;
    logic uv_req_synced;
    logic pin_exit_synced;
    logic [1:0] async_ins;
    wire logic [1:0] sync_second;

    // Slot 0 carries the monitor request, slot 1 the pin exit
    assign async_ins = {stop_exit_by_reset_pin_in, undervolt_reset_request_in};

    // Reset asserts at once, releases two edges later
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Two flops per asynchronous input; only the second one is ever read
    // Two cycles of lag are the price for a settled level
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_sync
            logic first_ff;
            logic second_ff;

            // Cleared with the internal reset, so no stale request survives it
            always_ff @(posedge sys_clk_in or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    first_ff <= 1'b0;
                    second_ff <= 1'b0;
                end
                else
                begin
                    first_ff <= async_ins[i];
                    second_ff <= first_ff;
                end
            end

            assign sync_second[i] = second_ff;
        end
    endgenerate

    // Named views for the decoding further down
    assign uv_req_synced = sync_second[0];
    assign pin_exit_synced = sync_second[1];

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture

    logic phase_write;
    logic phase_read;
    logic [7:0] phase_addr;
    logic addr_valid;

    function automatic logic is_active(input logic [1:0] trans);
        is_active = (trans == option_latch_pkg::HTRANS_NONSEQ) ||
            (trans == option_latch_pkg::HTRANS_SEQ);
    endfunction

    // A transfer is taken only while the bus is ready and we are selected
    // Idle and busy cycles never reach the decoder
    assign addr_valid = hsel_in && hready_in && is_active(htrans_in);

    // Data phase follows one cycle behind; slave never waits
    always_ff @(posedge sys_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            phase_write <= 1'b0;
            phase_read <= 1'b0;
            phase_addr <= 8'h00;
        end
        else
        begin
            phase_write <= addr_valid && hwrite_in;
            phase_read <= addr_valid && !hwrite_in;
            phase_addr <= haddr_in[7:0];
        end
    end

    // Zero wait states: every access finishes in its own data phase
    // Refused writes still answer OKAY, software gets no error signal
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Option latches

    logic [7:0] options;
    logic written;
    logic option_hit;

    assign option_hit = phase_write &&
        (phase_addr == option_latch_pkg::OPTION_BYTE_ADDR);

    // Only the first write lands; later ones are dropped silently
    // The written flag has no clear but reset, so the lock cannot reopen
    // Plain flip-flops, not storage: every reset brings back the defaults
    always_ff @(posedge sys_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            options <= option_latch_pkg::OPTION_RESET;
            written <= 1'b0;
        end
        else if (option_hit && !written)
        begin
            options <= hwdata_in[7:0];
            written <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Unmapped words read zero
    always_ff @(posedge sys_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            hrdata_out <= 32'h00000000;
        end
        else if (addr_valid && !hwrite_in)
        begin
            if (haddr_in[7:0] == option_latch_pkg::OPTION_BYTE_ADDR)
            begin
                hrdata_out <= {24'h000000, next_options_view()};
            end
            else if (haddr_in[7:0] == option_latch_pkg::STATUS_BYTE_ADDR)
            begin
                hrdata_out <= {31'h00000000, next_written_view()};
            end
            else
            begin
                hrdata_out <= 32'h00000000;
            end
        end
    end

    // Read right behind the write sees the new byte
    function automatic logic [7:0] next_options_view();
        next_options_view = (option_hit && !written) ? hwdata_in[7:0] : options;
    endfunction

    // Status read right behind the write sees the lock already taken
    function automatic logic next_written_view();
        next_written_view = written || option_hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Option decoding to the other modules

    // One option bit by its field position; used by every output below
    function automatic logic opt_bit(input int pos);
        opt_bit = options[pos];
    endfunction

    // Outputs are levels from the latched byte; gated request, stop answers and recovery length also follow their inputs
    // The byte changes only on reset and on the edge that takes the one permitted write

    // Range select for generator and clock monitor
    // Both halves must switch together or the monitor trips falsely
    assign slow_crystal_select_out =
        opt_bit(option_latch_pkg::SLOW_CRYSTAL_BIT);

    // Power gate for the undervolt monitor
    assign undervolt_power_enable_out =
        opt_bit(option_latch_pkg::UNDERVOLT_POWER_BIT);

    // Stop-mode running needs power too
    // A stop enable alone would leave the monitor half configured
    assign undervolt_stop_active_out =
        opt_bit(option_latch_pkg::UNDERVOLT_STOP_BIT) &&
        opt_bit(option_latch_pkg::UNDERVOLT_POWER_BIT);

    // Monitor reset request, synchronised, then gated by its option
    assign undervolt_reset_request_in_gated_out = uv_req_synced &&
        opt_bit(option_latch_pkg::UNDERVOLT_RESET_BIT);

    // Timeout length for the watchdog counter; counting lives elsewhere
    assign watchdog_timeout_cycles_out =
        opt_bit(option_latch_pkg::WATCHDOG_RATE_BIT) ?
        option_latch_pkg::WATCHDOG_FAST_CYCLES :
        option_latch_pkg::WATCHDOG_SLOW_CYCLES;

    // Watchdog off switch; stays enabled until software says otherwise
    assign watchdog_disable_out =
        opt_bit(option_latch_pkg::WATCHDOG_DISABLE_BIT);

    // Decoder asks per opcode; answer is combinational
    // Exactly one of the two answers is high while the opcode is asked
    assign stop_illegal_out = stop_opcode_in &&
        !opt_bit(option_latch_pkg::STOP_ENABLE_BIT);
    assign stop_execute_out = stop_opcode_in &&
        opt_bit(option_latch_pkg::STOP_ENABLE_BIT);

    // Pin exit overrides the short choice
    // The long delay also covers the monitor turn-on time after a pin exit
    assign stop_recovery_cycles_out =
        (opt_bit(option_latch_pkg::SHORT_RECOVERY_BIT) && !pin_exit_synced) ?
        option_latch_pkg::RECOVERY_SHORT_CYCLES :
        option_latch_pkg::RECOVERY_LONG_CYCLES;

endmodule
`default_nettype wire

// >>> tb/option_latch_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module option_latch_monitor (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic undervolt_power_enable_out,
    input wire logic undervolt_stop_active_out,
    input wire logic undervolt_reset_request_in,
    input wire logic undervolt_reset_request_in_gated_out,
    input wire logic [17:0] watchdog_timeout_cycles_out,
    input wire logic stop_opcode_in,
    input wire logic stop_illegal_out,
    input wire logic stop_execute_out,
    input wire logic stop_exit_by_reset_pin_in,
    input wire logic [12:0] stop_recovery_cycles_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    ////////////////////////////////////////////////////////////////
    // Zero wait states, always OKAY
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus slave stalled or flagged an error");
    // Stop-mode monitoring is useless without power
    a_stop_power: assert property (
        undervolt_stop_active_out |-> undervolt_power_enable_out)
        else $error("undervolt stop active without power");
    a_wd_codes: assert property (
        watchdog_timeout_cycles_out == option_latch_pkg::WATCHDOG_FAST_CYCLES
        || watchdog_timeout_cycles_out == option_latch_pkg::WATCHDOG_SLOW_CYCLES)
        else $error("watchdog timeout not a legal length");
    a_rec_codes: assert property (
        stop_recovery_cycles_out == option_latch_pkg::RECOVERY_SHORT_CYCLES
        || stop_recovery_cycles_out == option_latch_pkg::RECOVERY_LONG_CYCLES)
        else $error("recovery delay not a legal length");
    // Three samples cover the two-flop synchroniser
    a_rec_pin: assert property (
        stop_exit_by_reset_pin_in [*3] |->
        stop_recovery_cycles_out == option_latch_pkg::RECOVERY_LONG_CYCLES)
        else $error("pin exit did not force long recovery");
    a_stop_decode: assert property (
        stop_opcode_in == (stop_illegal_out | stop_execute_out)
        && !(stop_illegal_out && stop_execute_out))
        else $error("stop opcode decode wrong");
    a_uv_block: assert property (
        !undervolt_reset_request_in [*3] |-> !undervolt_reset_request_in_gated_out)
        else $error("undervolt reset passed with no request");
    a_uv_pass: assert property (
        undervolt_reset_request_in_gated_out |-> $past(undervolt_reset_request_in, 2))
        else $error("undervolt reset not from a synced request");
endmodule
bind write_once_option_register option_latch_monitor u_option_latch_monitor (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .undervolt_power_enable_out(undervolt_power_enable_out),
    .undervolt_stop_active_out(undervolt_stop_active_out),
    .undervolt_reset_request_in(undervolt_reset_request_in),
    .undervolt_reset_request_in_gated_out(undervolt_reset_request_in_gated_out),
    .watchdog_timeout_cycles_out(watchdog_timeout_cycles_out), .stop_opcode_in(stop_opcode_in),
    .stop_illegal_out(stop_illegal_out), .stop_execute_out(stop_execute_out),
    .stop_exit_by_reset_pin_in(stop_exit_by_reset_pin_in),
    .stop_recovery_cycles_out(stop_recovery_cycles_out));
`default_nettype wire

// >>> tb/write_once_option_register_test.sv
`timescale 1ns/1ps
`default_nettype none
module write_once_option_register_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic req = 1'b0;
    logic op = 1'b0;
    logic pin = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic rdy, resp, slow, pwr, act, gated, wdd, ill, exe;
    logic [17:0] tmo;
    logic [12:0] rec;
    int error_cnt = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    write_once_option_register u_write_once_option_register (
        .sys_clk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(resp),
        .slow_crystal_select_out(slow), .undervolt_power_enable_out(pwr),
        .undervolt_stop_active_out(act), .undervolt_reset_request_in_gated_out(gated),
        .undervolt_reset_request_in(req), .watchdog_timeout_cycles_out(tmo),
        .watchdog_disable_out(wdd), .stop_opcode_in(op), .stop_illegal_out(ill),
        .stop_execute_out(exe), .stop_exit_by_reset_pin_in(pin), .stop_recovery_cycles_out(rec));
    ////////////////////////////////////////////////////////////////
    task summarize;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single AHB transfer; waits on hready, never on a fixed count
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= option_latch_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    // Past the reset-request and pin synchronisers
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [63:0] outs;
        return {29'h0, slow, pwr, act, wdd, tmo, rec};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        xfer(1'b0, 32'h7C, 32'h0);
        chk(rd, {24'h0, option_latch_pkg::OPTION_RESET});
        chk(outs(), {29'h0, 4'h4, 18'h3FFF0, 13'h1000});
        xfer(1'b0, 32'h80, 32'h0);
        chk(rd, 64'h0);
        xfer(1'b1, 32'h40, 32'hFF);
        xfer(1'b0, 32'h40, 32'h0);
        chk(rd, 64'h0);
        xfer(1'b1, 32'h7C, 32'hEE);
        settle();
        chk(outs(), {29'h0, 4'h8, 18'h01FF0, 13'h0020});
        xfer(1'b0, 32'h80, 32'h0);
        chk(rd, 64'h1);
        @(posedge clk);
        op <= 1'b1;
        req <= 1'b1;
        settle();
        chk({ill, exe, gated}, 64'h3);
        @(posedge clk);
        pin <= 1'b1;
        settle();
        chk(rec, 64'h1000);
        @(posedge clk);
        pin <= 1'b0;
        xfer(1'b1, 32'h7C, 32'h11);
        xfer(1'b0, 32'h7C, 32'h0);
        chk(rd, 64'hEE);
        do_reset();
        xfer(1'b1, 32'h7C, 32'h51);
        settle();
        chk(outs(), {29'h0, 4'h7, 18'h3FFF0, 13'h1000});
        chk({ill, exe, gated}, 64'h4);
        summarize();
    end
    // Whole run is under 60 cycles, against a limit of 400
    initial
    begin
        #20000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
